/* design/plr_regs.sv */
// plr_regs: loop-filter, lock-detect and channel-1 control words of the clock generator.
// assumes the serial configuration port decodes into one-cycle read/write strobes on ref_clk_i.
// assumes sys_rst_i is already synchronous to ref_clk_i, so it is used without a synchroniser.
`timescale 1ns/1ps

module plr_regs (
   // clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 sys_rst_i,
   // register port
   input  wire plr_pkg::plr_req_s    req_i,
   output logic [plr_pkg::DATA_W-1:0] rdata_o,
   output logic                      rvalid_o,
   output logic                      hit_o,
   // decoded analog controls
   output plr_pkg::plr_ctrl_s        ctrl_o,
   // raw channel-1 words
   output logic [plr_pkg::DATA_W-1:0] ch1_word_a_o,
   output logic [plr_pkg::DATA_W-1:0] ch1_word_b_o,
   output logic [plr_pkg::DATA_W-1:0] ch1_word_c_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // storage: the five words exactly as software wrote them
   logic [plr_pkg::DATA_W-1:0] lf_b_reg,   lf_b_next;
   logic [plr_pkg::DATA_W-1:0] lock_reg,   lock_next;
   logic [plr_pkg::DATA_W-1:0] cha_reg,    cha_next;
   logic [plr_pkg::DATA_W-1:0] chb_reg,    chb_next;
   logic [plr_pkg::DATA_W-1:0] chc_reg,    chc_next;

   // read response
   logic [plr_pkg::DATA_W-1:0] rdata_reg,  rdata_next;
   logic                       rvalid_reg, rvalid_next;
   logic                       hit_reg,    hit_next;

   // decoded controls
   plr_pkg::plr_ctrl_s         ctrl_reg,   ctrl_next;
   logic [plr_pkg::RES_W-1:0]  res_code;
   logic [plr_pkg::PCAP_W-1:0] pcap_code;
   logic [plr_pkg::DLY_W-1:0]  dly_code;
   logic [plr_pkg::WIN_W-1:0]  win_code;
   logic [plr_pkg::WAIT_W-1:0] wait_code;

   // address selects and per-word write strobes
   logic                       sel_lf_b;
   logic                       sel_lock;
   logic                       sel_cha;
   logic                       sel_chb;
   logic                       sel_chc;
   logic                       sel_any;
   logic                       wr_lf_b;
   logic                       wr_lock;
   logic                       wr_cha;
   logic                       wr_chb;
   logic                       wr_chc;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode, shared by the write and the read path
   always_comb begin
      sel_lf_b = (req_i.addr == plr_pkg::ADDR_LOOP_FILTER_B);
      sel_lock = (req_i.addr == plr_pkg::ADDR_LOCK_CONTROL);
      sel_cha  = (req_i.addr == plr_pkg::ADDR_CH1_WORD_A);
      sel_chb  = (req_i.addr == plr_pkg::ADDR_CH1_WORD_B);
      sel_chc  = (req_i.addr == plr_pkg::ADDR_CH1_WORD_C);
      sel_any  = sel_lf_b | sel_lock | sel_cha | sel_chb | sel_chc;
      // an unmapped address raises no strobe, so such writes are dropped
      wr_lf_b  = req_i.wr & sel_lf_b;
      wr_lock  = req_i.wr & sel_lock;
      wr_cha   = req_i.wr & sel_cha;
      wr_chb   = req_i.wr & sel_chb;
      wr_chc   = req_i.wr & sel_chc;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write path: whole words, reserved bits and undefined codes included, so readback is exact
   always_comb begin
      lf_b_next = lf_b_reg;
      lock_next = lock_reg;
      cha_next  = cha_reg;
      chb_next  = chb_reg;
      chc_next  = chc_reg;
      if (wr_lf_b) begin
         lf_b_next = req_i.wdata;
      end
      if (wr_lock) begin
         lock_next = req_i.wdata;
      end
      if (wr_cha) begin
         cha_next = req_i.wdata;
      end
      if (wr_chb) begin
         chb_next = req_i.wdata;
      end
      if (wr_chc) begin
         chc_next = req_i.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path: answers one cycle after the strobe, unmapped reads give zero;
   // it reads the stored words, so a write in the same cycle is seen only by the next read
   always_comb begin
      rdata_next  = rdata_reg;
      hit_next    = hit_reg;
      rvalid_next = req_i.rd;
      if (req_i.rd) begin
         hit_next = sel_any;
         if (sel_lf_b) begin
            rdata_next = lf_b_reg;
         end else if (sel_lock) begin
            rdata_next = lock_reg;
         end else if (sel_cha) begin
            rdata_next = cha_reg;
         end else if (sel_chb) begin
            rdata_next = chb_reg;
         end else if (sel_chc) begin
            rdata_next = chc_reg;
         end else begin
            rdata_next = plr_pkg::RD_UNMAPPED;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field slices of the stored words
   always_comb begin
      res_code  = lf_b_reg[plr_pkg::RES_LSB +: plr_pkg::RES_W];
      pcap_code = lf_b_reg[plr_pkg::PCAP_LSB +: plr_pkg::PCAP_W];
      dly_code  = lock_reg[plr_pkg::DLY_LSB +: plr_pkg::DLY_W];
      win_code  = lock_reg[plr_pkg::WIN_LSB +: plr_pkg::WIN_W];
      wait_code = lock_reg[plr_pkg::WAIT_LSB +: plr_pkg::WAIT_W];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // field decode, registered so the analog side sees glitch-free levels;
   // codes past the defined range stay as written and only their valid flag drops
   always_comb begin

      ctrl_next.zero_res_code  = res_code;
      ctrl_next.zero_res_open  = (res_code == plr_pkg::RES_OPEN);
      ctrl_next.zero_res_valid = (res_code <= plr_pkg::RES_CODE_MAX);
      ctrl_next.pole_cap_code  = pcap_code;
      ctrl_next.pole_cap_valid = (pcap_code <= plr_pkg::PCAP_CODE_MAX);
      case (dly_code)
         2'h0:    ctrl_next.pfd_reset_delay = plr_pkg::DLY_P0;
         2'h1:    ctrl_next.pfd_reset_delay = plr_pkg::DLY_P1;
         2'h2:    ctrl_next.pfd_reset_delay = plr_pkg::DLY_P2;
         default: ctrl_next.pfd_reset_delay = plr_pkg::DLY_P3;
      endcase
      ctrl_next.lock_window_code = win_code;
      // window code 0h turns lock detection off whatever the timer field holds
      ctrl_next.lock_detect_en   = (win_code != plr_pkg::WIN_OFF);
      case (wait_code)
         2'h0:    ctrl_next.lock_wait_cycles = plr_pkg::WAIT_C0;
         2'h1:    ctrl_next.lock_wait_cycles = plr_pkg::WAIT_C1;
         2'h2:    ctrl_next.lock_wait_cycles = plr_pkg::WAIT_C2;
         default: ctrl_next.lock_wait_cycles = plr_pkg::WAIT_C3;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register words, synchronous reset to their power-up values
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         lf_b_reg <= plr_pkg::RST_LOOP_FILTER_B;
         lock_reg <= plr_pkg::RST_LOCK_CONTROL;
         cha_reg  <= plr_pkg::RST_CH1_WORD_A;
         chb_reg  <= plr_pkg::RST_CH1_WORD_B;
         chc_reg  <= plr_pkg::RST_CH1_WORD_C;
      end else begin
         lf_b_reg <= lf_b_next;
         lock_reg <= lock_next;
         cha_reg  <= cha_next;
         chb_reg  <= chb_next;
         chc_reg  <= chc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read response; rdata_o and hit_o hold the last answer until the next read strobe
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_reg  <= plr_pkg::RD_UNMAPPED;
         rvalid_reg <= 1'b0;
         hit_reg    <= 1'b0;
      end else begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
         hit_reg    <= hit_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decoded controls: zeros in reset, decoded reset values one edge after release
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   assign rdata_o      = rdata_reg;
   assign rvalid_o     = rvalid_reg;
   assign hit_o        = hit_reg;
   assign ctrl_o       = ctrl_reg;
   assign ch1_word_a_o = cha_reg;
   assign ch1_word_b_o = chb_reg;
   assign ch1_word_c_o = chc_reg;

endmodule // plr_regs

/* design/plr_pkg.sv */
// plr_pkg: register map, field layout and decode tables for the loop-filter and
// lock-detect register slice. assumes 16-bit register words addressed by 8-bit index.
package plr_pkg;

   localparam int           DATA_W = 16;
   localparam int           ADDR_W = 8;

   // register addresses
   localparam logic [7:0]   ADDR_LOOP_FILTER_B = 8'h1F;
   localparam logic [7:0]   ADDR_LOCK_CONTROL  = 8'h21;
   localparam logic [7:0]   ADDR_CH1_WORD_A    = 8'h23;
   localparam logic [7:0]   ADDR_CH1_WORD_B    = 8'h24;
   localparam logic [7:0]   ADDR_CH1_WORD_C    = 8'h25;

   // reset values
   localparam logic [15:0]  RST_LOOP_FILTER_B = 16'h1E72;
   localparam logic [15:0]  RST_LOCK_CONTROL  = 16'h0007;
   localparam logic [15:0]  RST_CH1_WORD_A    = 16'h8000;
   localparam logic [15:0]  RST_CH1_WORD_B    = 16'h0000;
   localparam logic [15:0]  RST_CH1_WORD_C    = 16'h8003;
   localparam logic [15:0]  RD_UNMAPPED       = 16'h0000;

   // field positions
   localparam int           RES_LSB    = 5;
   localparam int           RES_W      = 4;
   localparam int           PCAP_LSB   = 0;
   localparam int           PCAP_W     = 5;
   localparam int           DLY_LSB    = 5;
   localparam int           DLY_W      = 2;
   localparam int           WIN_LSB    = 2;
   localparam int           WIN_W      = 3;
   localparam int           WAIT_LSB   = 0;
   localparam int           WAIT_W     = 2;

   // highest defined codes, plus the open-resistor and window-off codes
   localparam logic [3:0]   RES_CODE_MAX  = 4'hC;
   localparam logic [4:0]   PCAP_CODE_MAX = 5'h14;
   localparam logic [3:0]   RES_OPEN      = 4'h0;
   localparam logic [2:0]   WIN_OFF       = 3'h0;

   // detector-period decodes
   localparam logic [3:0]   DLY_P0 = 4'h2;
   localparam logic [3:0]   DLY_P1 = 4'h6;
   localparam logic [3:0]   DLY_P2 = 4'hA;
   localparam logic [3:0]   DLY_P3 = 4'hE;
   localparam logic [7:0]   WAIT_C0 = 8'h01;
   localparam logic [7:0]   WAIT_C1 = 8'h10;
   localparam logic [7:0]   WAIT_C2 = 8'h40;
   localparam logic [7:0]   WAIT_C3 = 8'h80;

   typedef struct packed {
      logic               wr;
      logic               rd;
      logic [ADDR_W-1:0]  addr;
      logic [DATA_W-1:0]  wdata;
   } plr_req_s;

   typedef struct packed {
      logic [3:0] zero_res_code;
      logic       zero_res_open;
      logic       zero_res_valid;
      logic [4:0] pole_cap_code;
      logic       pole_cap_valid;
      logic [3:0] pfd_reset_delay;
      logic [2:0] lock_window_code;
      logic       lock_detect_en;
      logic [7:0] lock_wait_cycles;
   } plr_ctrl_s;

endpackage

/* testbench/plr_regs_properties.sv */
// plr_regs_chk: port-level properties of the loop-filter and lock register slice.
// assumes it is bound onto plr_regs; one clock, synchronous active-high reset.
`timescale 1ns/1ps
module plr_regs_chk (
   // clock and reset
   input wire logic                       ref_clk_i,
   input wire logic                       sys_rst_i,
   // register port and decoded controls
   input wire plr_pkg::plr_req_s          req_i,
   input wire logic [plr_pkg::DATA_W-1:0] rdata_o,
   input wire logic                       rvalid_o,
   input wire logic                       hit_o,
   input wire plr_pkg::plr_ctrl_s         ctrl_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   localparam logic [7:0] WT [4] = '{8'h01, 8'h10, 8'h40, 8'h80};
   wire m   = req_i.addr inside {8'h1F, 8'h21, 8'h23, 8'h24, 8'h25};
   wire w21 = req_i.wr && req_i.addr == 8'h21;
   wire w1f = req_i.wr && req_i.addr == 8'h1F;
   ////////////////////////////////////////////////////////////////////////
   // decode checks skip a second write in the next cycle, which moves ctrl again
   property p_rv; 1 |=> rvalid_o == $past(req_i.rd); endproperty
   a_rv: assert property (p_rv) else $error("read valid timing wrong");
   property p_hit; req_i.rd |=> hit_o == $past(m); endproperty
   a_hit: assert property (p_hit) else $error("hit flag wrong");
   property p_unm; req_i.rd && !m |=> rdata_o == 16'h0000; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_wr_rd; req_i.wr && m ##1 req_i.rd && req_i.addr == $past(req_i.addr)
      |=> rdata_o == $past(req_i.wdata, 2); endproperty
   a_wr_rd: assert property (p_wr_rd) else $error("write not read back");
   property p_dly; w21 ##1 !w21
      |=> ctrl_o.pfd_reset_delay == {$past(req_i.wdata[6:5], 2), 2'b00} + 4'h2; endproperty
   a_dly: assert property (p_dly) else $error("reset delay decode wrong");
   property p_win; w21 ##1 !w21 |=> ctrl_o.lock_window_code == $past(req_i.wdata[4:2], 2)
      && ctrl_o.lock_detect_en == ($past(req_i.wdata[4:2], 2) != 3'h0); endproperty
   a_win: assert property (p_win) else $error("lock window decode wrong");
   property p_wait; w21 ##1 !w21
      |=> ctrl_o.lock_wait_cycles == WT[$past(req_i.wdata[1:0], 2)]; endproperty
   a_wait: assert property (p_wait) else $error("lock timer decode wrong");
   property p_res; w1f ##1 !w1f |=> ctrl_o.zero_res_code == $past(req_i.wdata[8:5], 2)
      && ctrl_o.zero_res_open == ($past(req_i.wdata[8:5], 2) == 4'h0); endproperty
   a_res: assert property (p_res) else $error("zero resistor decode wrong");
   property p_pcap; w1f ##1 !w1f
      |=> ctrl_o.pole_cap_code == $past(req_i.wdata[4:0], 2); endproperty
   a_pcap: assert property (p_pcap) else $error("pole capacitor code wrong");
endmodule // plr_regs_chk

bind plr_regs plr_regs_chk plr_regs_chk_i (.ref_clk_i, .sys_rst_i, .req_i, .rdata_o,
   .rvalid_o, .hit_o, .ctrl_o);

/* testbench/plr_regs_tb_top.sv */
// plr_regs_tb_top: self-checking bench for the loop-filter and lock register slice.
// assumes plr_pkg, plr_regs and the bound checker are compiled before it.
`timescale 1ns/1ps
module plr_regs_tb_top;
   logic               ref_clk_i = 1'b0;
   logic               sys_rst_i = 1'b1;
   plr_pkg::plr_req_s  req = '0;
   logic [15:0]        rdata, cha, chb, chc, v;
   logic               rvalid, hit;
   plr_pkg::plr_ctrl_s ctrl;
   logic [16:0]        expq [$];
   logic [15:0]        mdl [logic [7:0]];
   int                 mismatches = 0;
   int                 cmp_count = 0;
   localparam logic [7:0] AD [8] = '{8'h1F, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h00, 8'hFF};
   localparam logic [7:0] WT [4] = '{8'h01, 8'h10, 8'h40, 8'h80};
   plr_regs plr_regs_i (.ref_clk_i, .sys_rst_i, .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
      .hit_o(hit), .ctrl_o(ctrl), .ch1_word_a_o(cha), .ch1_word_b_o(chb), .ch1_word_c_o(chc));
   initial begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rst_model();
      mdl[8'h1F] = 16'h1E72;
      mdl[8'h21] = 16'h0007;
      mdl[8'h23] = 16'h8000;
      mdl[8'h24] = 16'h0000;
      mdl[8'h25] = 16'h8003;
   endtask
   // the read is noted before the write lands: a same-cycle read sees the old word
   task automatic drive(logic w, logic r, logic [7:0] a, logic [15:0] d);
      logic hm;
      hm = 1'(mdl.exists(a));
      @(posedge ref_clk_i);
      req <= '{wr: w, rd: r, addr: a, wdata: d};
      if (r) expq.push_back({hm, hm ? mdl[a] : 16'h0000});
      if (w && hm) mdl[a] = d;
   endtask
   task automatic chk_ctrl();
      logic [15:0] lf;
      logic [15:0] lk;
      lf = mdl[8'h1F];
      lk = mdl[8'h21];
      chk("ctrl", {lf[8:5], (lf[8:5] == 4'h0), (lf[8:5] <= 4'hC), lf[4:0], (lf[4:0] <= 5'h14),
         {lk[6:5], 2'b00} + 4'h2, lk[4:2], (lk[4:2] != 3'h0), WT[lk[1:0]]},
         {ctrl.zero_res_code, ctrl.zero_res_open, ctrl.zero_res_valid, ctrl.pole_cap_code,
         ctrl.pole_cap_valid, ctrl.pfd_reset_delay, ctrl.lock_window_code,
         ctrl.lock_detect_en, ctrl.lock_wait_cycles});
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      if (rvalid === 1'b1) begin
         if (expq.size() == 0) chk("spurious read", 48'h1, 48'h0);
         else chk("read", expq.pop_front(), {hit, rdata});
      end
   end
   initial begin
      #100000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      v = 16'($urandom(37));
      rst_model();
      repeat (16) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      foreach (AD[j]) drive(0, 1, AD[j], 16'h0000);
      drive(0, 0, 8'h00, 16'h0000);
      chk_ctrl();
      $display("test reset values done");
      for (int i = 0; i < 16; i++) begin
         v = 16'($urandom);
         drive(1, 0, 8'h1F, {v[15:9], i[3:0], v[4:0]});
         drive(1, 1, 8'h21, {v[8:0], i[1:0], i[2:0], i[1:0]});
         drive(1, 0, 8'(8'h23 + i % 3), v);
         drive(0, 1, 8'(8'h23 + i % 3), 16'h0000);
         drive(1, 1, 8'h22, ~v);
         drive(0, 0, 8'h00, 16'h0000);
         drive(0, 0, 8'h00, 16'h0000);
         chk_ctrl();
         chk("ch1 words", {mdl[8'h23], mdl[8'h24], mdl[8'h25]}, {cha, chb, chc});
         foreach (AD[j]) drive(0, 1, AD[j], 16'h0000);
      end
      $display("test write and decode done");
      repeat (3) drive(0, 0, 8'h00, 16'h0000);
      sys_rst_i <= 1'b1;
      rst_model();
      repeat (2) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      foreach (AD[j]) drive(0, 1, AD[j], 16'h0000);
      repeat (3) drive(0, 0, 8'h00, 16'h0000);
      chk_ctrl();
      chk("ch1 words", {mdl[8'h23], mdl[8'h24], mdl[8'h25]}, {cha, chb, chc});
      chk("unanswered reads", 48'h0, 48'(expq.size()));
      $display("test second reset done");
      report_and_stop();
   end
endmodule // plr_regs_tb_top
